// File: core/sbrl_loader.sv
// Contract
// - Serial starts at 9600 baud, 8N1.
// - Eight-byte instruction buffer at 0xFFFFFFAA.
// - Only serial records drive boot actions.
// - Break pin low at reset enters boot.
// - Boot mode beats normal and emulation.
// - Reset vector fetch returns internal SP, PC.
// - Reserved vector reads return invalid data.
// - Record: address, count, data, hex, CR.
// - Nonzero count writes bytes consecutively.
// - Zero count starts execution at address.
// - Buffer execution returns to the loader.
// - Every received character after the first is echoed; the code drops the echo of one that arrives while the transmitter is busy.
// - First character sets baud, ack with at-sign.
// - Baud write takes effect for final echo.
// - Writes are single bytes, count bytes per record.
// - Non-hex character restarts record assembly.
// - Codes below 0x30 restart, still echoed.
`timescale 1ns/100ps
`include "sbrl_params.svh"

module sbrl_loader
    import sbrl_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             emulation_break_pin_in,
    input  wire logic             emul_strap_in,
    input  wire logic             rxd_in,
    input  wire logic             exec_done_in,
    input  wire logic             vec_fetch_in,
    input  wire logic [31:0]      rd_addr_in,
    output logic                  txd_out,
    output sbrl_pkg::sbrl_mode_t  mode_out,
    output sbrl_pkg::sbrl_vec_t   vec_out,
    output logic                  rd_invalid_out,
    output sbrl_pkg::sbrl_wr_t    wr_out,
    output sbrl_pkg::sbrl_exec_t  exec_out,
    output logic                  ibuf_exec_out,
    output logic [63:0]           instruction_buffer_out,
    output logic [DIV_W-1:0]      baud_div_out
);
    import sbrl_pkg::*;

    typedef enum logic [2:0] {
        SBRL_ST_STRAP, SBRL_ST_SYNC, SBRL_ST_ACK, SBRL_ST_ADDR,
        SBRL_ST_COUNT, SBRL_ST_DATA, SBRL_ST_RUN
    } sbrl_st_t;

    localparam logic [DIV_W-1:0] BOOT_DIV = DIV_W'(`SBRL_BAUD_DIV);

    sbrl_st_t          st_q, st_d;
    sbrl_mode_t        mode_q, mode_d;
    logic [DIV_W-1:0]  div_q, div_d;
    logic [DIV_W-1:0]  sync_q, sync_d;
    logic [31:0]       addr_q, addr_d;
    logic [7:0]        cnt_q, cnt_d;
    logic [7:0]        byte_q, byte_d;
    logic              nib_q, nib_d;
    logic [3:0]        ndig_q, ndig_d;
    logic [63:0]       ibuf_q, ibuf_d;
    sbrl_wr_t          wr_q, wr_d;
    sbrl_exec_t        ex_q, ex_d;
    logic              ibx_q, ibx_d;
    logic              echo_q, echo_d;
    logic [7:0]        echo_ch_q, echo_ch_d;
    logic              rdinv_q, rdinv_d;
    sbrl_vec_t         vec_q;

    logic              rx_vld;
    logic [7:0]        rx_ch;
    logic              tx_busy;
    logic              is_hex;
    logic [3:0]        hexval;
    logic [7:0]        full_byte;
    logic [2:0]        ib_idx;
    logic              rx_line;

    // The receiver is held idle while the first character sets the rate.
    assign rx_line = rxd_in || st_q == SBRL_ST_STRAP || st_q == SBRL_ST_SYNC ||
                     st_q == SBRL_ST_ACK;

    sbrl_uart_rx #(.DIV_W(DIV_W)) u_rx (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .div_in    (div_q),
        .rxd_in    (rx_line),
        .valid_out (rx_vld),
        .data_out  (rx_ch)
    );

    sbrl_uart_tx #(.DIV_W(DIV_W)) u_tx (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .div_in    (div_q),
        .start_in  (echo_q),
        .data_in   (echo_ch_q),
        .busy_out  (tx_busy),
        .txd_out   (txd_out)
    );

    // Only upper-case hex digits are record digits.
    always_comb begin
        is_hex = 1'b1;
        hexval = 4'h0;
        if (rx_ch >= 8'h30 && rx_ch <= 8'h39) begin
            hexval = rx_ch[3:0];
        end else if (rx_ch >= 8'h41 && rx_ch <= 8'h46) begin
            hexval = rx_ch[3:0] + 4'h9;
        end else begin
            is_hex = 1'b0;
        end
    end

    assign full_byte = {byte_q[3:0], hexval};
    assign ib_idx    = 3'(addr_q - `SBRL_IBUF_BASE);

    always_comb begin
        st_d      = st_q;
        mode_d    = mode_q;
        div_d     = div_q;
        sync_d    = sync_q;
        addr_d    = addr_q;
        cnt_d     = cnt_q;
        byte_d    = byte_q;
        nib_d     = nib_q;
        ndig_d    = ndig_q;
        ibuf_d    = ibuf_q;
        wr_d      = '0;
        ex_d      = '0;
        ibx_d     = ibx_q;
        echo_d    = 1'b0;
        echo_ch_d = echo_ch_q;
        rdinv_d   = 1'b0;
        // Boot mode hides the reserved vector ranges from reads.
        if (mode_q == SBRL_MODE_BOOT) begin
            rdinv_d = (rd_addr_in <= `SBRL_RESV_VEC_HI) ||
                      (rd_addr_in >= `SBRL_RESV_ALINE_LO &&
                       rd_addr_in <= `SBRL_RESV_ALINE_HI);
        end
        unique case (st_q)
            SBRL_ST_STRAP: begin
                if (!emulation_break_pin_in) begin
                    mode_d = SBRL_MODE_BOOT;
                    div_d  = BOOT_DIV;
                    st_d   = SBRL_ST_SYNC;
                end else begin
                    mode_d = emul_strap_in ? SBRL_MODE_EMUL : SBRL_MODE_NORMAL;
                    st_d   = SBRL_ST_RUN;
                end
            end
            SBRL_ST_SYNC: begin
                // Measure the start bit of the first character to set the rate.
                if (!rxd_in) begin
                    sync_d = sync_q + 1'b1;
                end else if (sync_q != '0) begin
                    div_d  = sync_q;
                    sync_d = '0;
                    ndig_d = 4'h0;
                    st_d   = SBRL_ST_ACK;
                end
            end
            SBRL_ST_ACK: begin
                // Let the rest of the first frame pass, then acknowledge.
                if (sync_q == div_q - 1'b1) begin
                    sync_d = '0;
                    ndig_d = ndig_q + 4'h1;
                    if (ndig_q == 4'h8) begin
                        echo_d    = 1'b1;
                        echo_ch_d = `SBRL_ACK_CHAR;
                        st_d      = SBRL_ST_ADDR;
                        ndig_d    = 4'h0;
                        nib_d     = 1'b0;
                    end
                end else begin
                    sync_d = sync_q + 1'b1;
                end
            end
            SBRL_ST_RUN: begin
                if (mode_q == SBRL_MODE_BOOT && exec_done_in) begin
                    ibx_d = 1'b0;
                    st_d  = SBRL_ST_ADDR;
                end
            end
            default: begin
                if (rx_vld) begin
                    echo_d    = 1'b1;
                    echo_ch_d = rx_ch;
                    if (!is_hex) begin
                        if (rx_ch == `SBRL_CR_CHAR && st_q == SBRL_ST_COUNT &&
                            ndig_q == 4'(`SBRL_HEX_PER_HDR) && cnt_q == 8'h00) begin
                            ex_d.valid = 1'b1;
                            ex_d.addr  = addr_q;
                            ibx_d      = (addr_q == `SBRL_IBUF_BASE);
                            st_d       = SBRL_ST_RUN;
                        end else begin
                            st_d = SBRL_ST_ADDR;
                        end
                        ndig_d = 4'h0;
                        nib_d  = 1'b0;
                    end else begin
                        nib_d  = !nib_q;
                        byte_d = full_byte;
                        unique case (st_q)
                            SBRL_ST_ADDR: begin
                                addr_d = {addr_q[27:0], hexval};
                                ndig_d = ndig_q + 4'h1;
                                if (ndig_q == 4'h7) begin
                                    st_d = SBRL_ST_COUNT;
                                end
                                nib_d = 1'b0;
                            end
                            SBRL_ST_COUNT: begin
                                ndig_d = ndig_q + 4'h1;
                                if (nib_q) begin
                                    cnt_d = full_byte;
                                    if (full_byte != 8'h00) begin
                                        st_d = SBRL_ST_DATA;
                                    end
                                end
                            end
                            SBRL_ST_DATA: begin
                                if (nib_q) begin
                                    wr_d.valid = 1'b1;
                                    wr_d.addr  = addr_q;
                                    wr_d.data  = full_byte;
                                    if (addr_q >= `SBRL_IBUF_BASE &&
                                        addr_q < `SBRL_IBUF_BASE + `SBRL_IBUF_BYTES) begin
                                        ibuf_d[{~ib_idx, 3'h0} +: 8] = full_byte;
                                    end
                                    if (addr_q == `SBRL_BAUD_REG_LO) begin
                                        div_d = DIV_W'((32'(div_q) * 32'h26) /
                                                (32'(full_byte) + 32'h1));
                                    end
                                    addr_d = addr_q + 32'h1;
                                    cnt_d  = cnt_q - 8'h1;
                                    if (cnt_q == 8'h01) begin
                                        st_d   = SBRL_ST_ADDR;
                                        ndig_d = 4'h0;
                                    end
                                end
                            end
                            default: begin
                                st_d = SBRL_ST_ADDR;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q      <= SBRL_ST_STRAP;
            mode_q    <= SBRL_MODE_NORMAL;
            div_q     <= BOOT_DIV;
            sync_q    <= '0;
            addr_q    <= 32'h0;
            cnt_q     <= 8'h00;
            byte_q    <= 8'h00;
            nib_q     <= 1'b0;
            ndig_q    <= 4'h0;
            ibuf_q    <= 64'h0;
            wr_q      <= '0;
            ex_q      <= '0;
            ibx_q     <= 1'b0;
            echo_q    <= 1'b0;
            echo_ch_q <= 8'h00;
            rdinv_q   <= 1'b0;
            vec_q     <= '0;
        end else begin
            st_q      <= st_d;
            mode_q    <= mode_d;
            div_q     <= div_d;
            sync_q    <= sync_d;
            addr_q    <= addr_d;
            cnt_q     <= cnt_d;
            byte_q    <= byte_d;
            nib_q     <= nib_d;
            ndig_q    <= ndig_d;
            ibuf_q    <= ibuf_d;
            wr_q      <= wr_d;
            ex_q      <= ex_d;
            ibx_q     <= ibx_d;
            echo_q    <= echo_d && !tx_busy;
            echo_ch_q <= echo_ch_d;
            rdinv_q   <= rdinv_d;
            // Vector words are loaded only while boot mode fetches them, then held.
            if (mode_q == SBRL_MODE_BOOT && vec_fetch_in) begin
                vec_q.sp <= `SBRL_BOOT_SP;
                vec_q.pc <= `SBRL_BOOT_PC;
            end
        end
    end

    assign mode_out               = mode_q;
    assign vec_out                = vec_q;
    assign rd_invalid_out         = rdinv_q;
    assign wr_out                 = wr_q;
    assign exec_out               = ex_q;
    assign ibuf_exec_out          = ibx_q;
    assign instruction_buffer_out = ibuf_q;
    assign baud_div_out           = div_q;
endmodule // sbrl_loader

// File: core/sbrl_params.svh
`ifndef SBRL_PARAMS_SVH
`define SBRL_PARAMS_SVH

`define SBRL_CLK_HZ          40000000
`define SBRL_BOOT_BAUD       9600
`define SBRL_BAUD_DIV        (`SBRL_CLK_HZ / `SBRL_BOOT_BAUD)
`define SBRL_IBUF_BASE       32'hffffffaa
`define SBRL_IBUF_BYTES      8
`define SBRL_BAUD_REG_HI     32'hfffff902
`define SBRL_BAUD_REG_LO     32'hfffff903
`define SBRL_BAUD_REG_RESET  16'h0126
`define SBRL_ACK_CHAR        8'h40
`define SBRL_CR_CHAR         8'h0d
`define SBRL_MIN_KEEP_CHAR   8'h30
`define SBRL_RESV_VEC_HI     32'h00000007
`define SBRL_RESV_ALINE_LO   32'h00000028
`define SBRL_RESV_ALINE_HI   32'h0000002b
`define SBRL_BOOT_SP         32'h00000000
`define SBRL_BOOT_PC         32'h00000000
`define SBRL_HEX_PER_HDR     10

`endif

// File: core/sbrl_pkg.sv
package sbrl_pkg;

    typedef enum logic [1:0] {
        SBRL_MODE_NORMAL,
        SBRL_MODE_EMUL,
        SBRL_MODE_BOOT
    } sbrl_mode_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [7:0]  data;
    } sbrl_wr_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } sbrl_exec_t;

    typedef struct packed {
        logic [31:0] sp;
        logic [31:0] pc;
    } sbrl_vec_t;

endpackage

// File: core/sbrl_uart_rx.sv
`timescale 1ns/100ps
`include "sbrl_params.svh"

module sbrl_uart_rx #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic [DIV_W-1:0] div_in,
    input  wire logic             rxd_in,
    output logic                  valid_out,
    output logic [7:0]            data_out
);
    typedef enum logic [1:0] {SBRL_RX_IDLE, SBRL_RX_START, SBRL_RX_DATA, SBRL_RX_STOP} sbrl_rx_t;

    sbrl_rx_t          st_q, st_d;
    logic [DIV_W-1:0]  cnt_q, cnt_d;
    logic [2:0]        bit_q, bit_d;
    logic [7:0]        sh_q, sh_d;
    logic              vld_q, vld_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sh_d  = sh_q;
        vld_d = 1'b0;
        unique case (st_q)
            SBRL_RX_IDLE: begin
                if (!rxd_in) begin
                    st_d  = SBRL_RX_START;
                    cnt_d = div_in >> 1;
                end
            end
            SBRL_RX_START: begin
                if (cnt_q == '0) begin
                    st_d  = rxd_in ? SBRL_RX_IDLE : SBRL_RX_DATA;
                    cnt_d = div_in - 1'b1;
                    bit_d = 3'h0;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SBRL_RX_DATA: begin
                if (cnt_q == '0) begin
                    sh_d  = {rxd_in, sh_q[7:1]};
                    cnt_d = div_in - 1'b1;
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        st_d = SBRL_RX_STOP;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SBRL_RX_STOP: begin
                if (cnt_q == '0) begin
                    st_d  = SBRL_RX_IDLE;
                    vld_d = rxd_in;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q  <= SBRL_RX_IDLE;
            cnt_q <= '0;
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
            vld_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            vld_q <= vld_d;
        end
    end

    assign valid_out = vld_q;
    assign data_out  = sh_q;
endmodule // sbrl_uart_rx

// File: core/sbrl_uart_tx.sv
`timescale 1ns/100ps
`include "sbrl_params.svh"

module sbrl_uart_tx #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic [DIV_W-1:0] div_in,
    input  wire logic             start_in,
    input  wire logic [7:0]       data_in,
    output logic                  busy_out,
    output logic                  txd_out
);
    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic [9:0]       sh_q, sh_d;
    logic [3:0]       left_q, left_d;
    logic             txd_q, txd_d;

    always_comb begin
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        left_d = left_q;
        txd_d  = txd_q;
        if (left_q == 4'h0) begin
            txd_d = 1'b1;
            // The stop bit runs out its full period before a new frame.
            if (cnt_q != '0) begin
                cnt_d = cnt_q - 1'b1;
            end else if (start_in) begin
                sh_d   = {1'b1, data_in, 1'b0};
                left_d = 4'ha;
                cnt_d  = '0;
            end
        end else if (cnt_q == '0) begin
            txd_d  = sh_q[0];
            sh_d   = {1'b1, sh_q[9:1]};
            left_d = left_q - 4'h1;
            cnt_d  = div_in - 1'b1;
        end else begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q  <= '0;
            sh_q   <= 10'h3ff;
            left_q <= 4'h0;
            txd_q  <= 1'b1;
        end else begin
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            left_q <= left_d;
            txd_q  <= txd_d;
        end
    end

    assign busy_out = (left_q != 4'h0) || start_in || (cnt_q != '0);
    assign txd_out  = txd_q;
endmodule // sbrl_uart_tx

// File: tb/sbrl_loader_asserts.sv
`timescale 1ns/100ps
`include "sbrl_params.svh"

module sbrl_loader_chk #(
    parameter int DIV_W = 16
) (
    input wire logic             clk_in,
    input wire logic             resetn_in,
    input wire logic             emulation_break_pin_in,
    input wire logic             emul_strap_in,
    input wire logic             rxd_in,
    input wire logic             exec_done_in,
    input wire logic             vec_fetch_in,
    input wire logic [31:0]      rd_addr_in,
    input wire logic             txd_out,
    input sbrl_pkg::sbrl_mode_t  mode_out,
    input sbrl_pkg::sbrl_vec_t   vec_out,
    input wire logic             rd_invalid_out,
    input sbrl_pkg::sbrl_wr_t    wr_out,
    input sbrl_pkg::sbrl_exec_t  exec_out,
    input wire logic             ibuf_exec_out,
    input wire logic [63:0]      instruction_buffer_out,
    input wire logic [DIV_W-1:0] baud_div_out
);
    import sbrl_pkg::*;
    logic [1:0] age_q;
    logic [1:0] age_d;

    always_comb begin
        age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            age_q <= 2'h0;
        end else begin
            age_q <= age_d;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    chk_boot_entry: assert property (
        $rose(resetn_in) && !emulation_break_pin_in |=> mode_out == SBRL_MODE_BOOT)
        else $error("boot mode not entered with break pin low");
    chk_mode_select: assert property (
        $rose(resetn_in) && emulation_break_pin_in |=>
        mode_out == ($past(emul_strap_in) ? SBRL_MODE_EMUL : SBRL_MODE_NORMAL))
        else $error("wrong mode without boot request");
    chk_mode_hold: assert property (age_q == 2'h3 |-> $stable(mode_out))
        else $error("mode changed after reset");
    chk_baud_reset: assert property ($rose(resetn_in) |-> baud_div_out == 16'h1046)
        else $error("divider not at the boot rate after reset");
    chk_vec_value: assert property (
        vec_fetch_in && $past(vec_fetch_in) && mode_out == SBRL_MODE_BOOT
        |-> vec_out == {`SBRL_BOOT_SP, `SBRL_BOOT_PC})
        else $error("boot vectors wrong");
    chk_rd_reserved: assert property (1'b1 |=> rd_invalid_out ==
        ($past(mode_out) == SBRL_MODE_BOOT && ($past(rd_addr_in) <= `SBRL_RESV_VEC_HI
        || ($past(rd_addr_in) >= `SBRL_RESV_ALINE_LO
        && $past(rd_addr_in) <= `SBRL_RESV_ALINE_HI))))
        else $error("reserved read flag wrong");
    chk_wr_pulse: assert property (wr_out.valid |=> !wr_out.valid)
        else $error("write pulse longer than one cycle");
    chk_action_boot: assert property (
        wr_out.valid || exec_out.valid |-> mode_out == SBRL_MODE_BOOT)
        else $error("action outside boot mode");
    chk_exec_pulse: assert property (exec_out.valid |=> !exec_out.valid)
        else $error("execute pulse longer than one cycle");
    chk_ibuf_start: assert property (
        exec_out.valid && exec_out.addr == `SBRL_IBUF_BASE |-> ##[0:1] ibuf_exec_out)
        else $error("buffer execution not started");
    chk_ibuf_end: assert property (ibuf_exec_out && exec_done_in |-> ##[1:2] !ibuf_exec_out)
        else $error("loader not resumed after buffer execution");

    cover property (exec_out.valid && exec_out.addr == `SBRL_IBUF_BASE);
    cover property (wr_out.valid);
    cover property (mode_out == SBRL_MODE_BOOT && rd_invalid_out);
endmodule // sbrl_loader_chk

bind sbrl_loader sbrl_loader_chk #(.DIV_W(DIV_W)) u_chk (
    .clk_in(clk_in), .resetn_in(resetn_in), .emulation_break_pin_in(emulation_break_pin_in),
    .emul_strap_in(emul_strap_in), .rxd_in(rxd_in), .exec_done_in(exec_done_in),
    .vec_fetch_in(vec_fetch_in), .rd_addr_in(rd_addr_in), .txd_out(txd_out),
    .mode_out(mode_out), .vec_out(vec_out), .rd_invalid_out(rd_invalid_out),
    .wr_out(wr_out), .exec_out(exec_out), .ibuf_exec_out(ibuf_exec_out),
    .instruction_buffer_out(instruction_buffer_out), .baud_div_out(baud_div_out)
);

// File: tb/sbrl_host_model.sv
`timescale 1ns/100ps

module sbrl_host_model (
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      line_out
);
    int         tx_clks = 24;
    int         rx_clks = 24;
    logic [7:0] rx_q[$];

    initial line_out = 1'b1;

    // Sends one 8N1 frame, least significant bit first, at the current rate.
    task automatic send_char(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            #1 line_out = f[i];
            repeat (tx_clks - 1) @(posedge clk_in);
        end
    endtask

    always begin : rx_proc
        logic [7:0] c;
        @(negedge line_in);
        repeat (rx_clks / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (rx_clks) @(posedge clk_in);
            c[i] = line_in;
        end
        repeat (rx_clks) @(posedge clk_in);
        rx_q.push_back(c);
    end
endmodule // sbrl_host_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
`include "sbrl_params.svh"

module tb_top;
    import sbrl_pkg::*;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        brk_pin = 1'b0;
    logic        strap = 1'b0;
    logic        rxd;
    logic        exec_done = 1'b0;
    logic        vec_fetch = 1'b0;
    logic [31:0] rd_addr = 32'h0;
    logic        txd;
    sbrl_mode_t  mode;
    sbrl_vec_t   vec;
    logic        rd_inv;
    sbrl_wr_t    wr;
    sbrl_exec_t  exe;
    logic        ibuf_exec;
    logic [63:0] ibuf;
    logic [15:0] div;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [39:0] wr_q[$];
    logic [31:0] ex_q[$];

    always #12.5 clk_in = ~clk_in;

    sbrl_loader uut (
        .clk_in(clk_in), .resetn_in(resetn_in), .emulation_break_pin_in(brk_pin),
        .emul_strap_in(strap), .rxd_in(rxd), .exec_done_in(exec_done),
        .vec_fetch_in(vec_fetch), .rd_addr_in(rd_addr), .txd_out(txd), .mode_out(mode),
        .vec_out(vec), .rd_invalid_out(rd_inv), .wr_out(wr), .exec_out(exe),
        .ibuf_exec_out(ibuf_exec), .instruction_buffer_out(ibuf), .baud_div_out(div)
    );
    sbrl_host_model host (.clk_in(clk_in), .line_in(txd), .line_out(rxd));

    always @(posedge clk_in) begin
        cycles++;
        if (wr.valid === 1'b1)
            wr_q.push_back({wr.addr, wr.data});
        if (exe.valid === 1'b1)
            ex_q.push_back(exe.addr);
        if (cycles == 90000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The host waits for each echo before sending on.
    task automatic send(input logic [7:0] c, input logic [7:0] echo);
        int n;
        host.send_char(c);
        for (n = 0; n < 2000 && host.rx_q.size() == 0; n++)
            @(posedge clk_in);
        check("echo", echo, host.rx_q.size() > 0 ? host.rx_q.pop_front() : 8'hxx);
    endtask

    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++)
            send(s[i], s[i]);
    endtask

    task automatic chk_wr(input logic [31:0] a, input logic [7:0] d);
        check("write", {a, d}, wr_q.size() > 0 ? wr_q.pop_front() : 40'hx);
    endtask

    task automatic do_reset(input logic brk, input logic st);
        @(posedge clk_in);
        #1 resetn_in = 1'b0;
        brk_pin = brk;
        strap = st;
        repeat (4) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 brk_pin = 1'b1;
    endtask

    task automatic t_modes;
        logic [1:0] cfg[3] = '{2'h2, 2'h3, 2'h1};
        sbrl_mode_t want[3] = '{SBRL_MODE_NORMAL, SBRL_MODE_EMUL, SBRL_MODE_BOOT};
        for (int i = 0; i < 3; i++) begin
            do_reset(cfg[i][1], cfg[i][0]);
            check("mode", want[i], mode);
            check("divider", 16'h1046, div);
            check("rd_invalid", want[i] == SBRL_MODE_BOOT, rd_inv);
        end
        $display("t_modes done");
    endtask

    task automatic t_vectors;
        logic [31:0] a[6] = '{32'h0, 32'h7, 32'h8, 32'h28, 32'h2b, 32'h2c};
        logic [5:0] hit = 6'h1b;
        vec_fetch = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            #1 rd_addr = a[i];
            repeat (2) @(posedge clk_in);
            #1 check("rd_invalid", hit[i], rd_inv);
        end
        check("vectors", {`SBRL_BOOT_SP, `SBRL_BOOT_PC}, vec);
        vec_fetch = 1'b0;
        rd_addr = 32'h0;
        $display("t_vectors done");
    endtask

    task automatic t_link;
        send(8'h61, `SBRL_ACK_CHAR);
        check("measured divider", 1, div >= 16'h17 && div <= 16'h19);
        $display("t_link done");
    endtask

    task automatic t_write;
        logic [23:0] d = 24'ha1b2c3;
        send_str("0000100003A1B2C3");
        for (int i = 0; i < 3; i++)
            chk_wr(32'h1000 + i, d[23 - 8 * i -: 8]);
        $display("t_write done");
    endtask

    task automatic t_ibuf;
        logic [63:0] code = 64'h303c00554e714e71;
        send_str("FFFFFFAA08303C00554E714E71");
        for (int i = 0; i < 8; i++)
            chk_wr(`SBRL_IBUF_BASE + i, code[63 - 8 * i -: 8]);
        check("buffer", code, ibuf);
        send_str("FFFFFFAA00");
        send(`SBRL_CR_CHAR, `SBRL_CR_CHAR);
        check("exec", `SBRL_IBUF_BASE, ex_q.size() > 0 ? ex_q.pop_front() : 32'hx);
        check("buffer running", 1'b1, ibuf_exec);
        @(posedge clk_in);
        #1 exec_done = 1'b1;
        @(posedge clk_in);
        #1 exec_done = 1'b0;
        repeat (2) @(posedge clk_in);
        check("buffer running", 1'b0, ibuf_exec);
        $display("t_ibuf done");
    endtask

    task automatic t_comment;
        send_str("12,00003000015AG00003001016B");
        chk_wr(32'h3000, 8'h5a);
        chk_wr(32'h3001, 8'h6b);
        check("spare writes", 0, wr_q.size());
        $display("t_comment done");
    endtask

    task automatic t_exec;
        send_str("0000400000");
        send(`SBRL_CR_CHAR, `SBRL_CR_CHAR);
        check("exec", 32'h4000, ex_q.size() > 0 ? ex_q.pop_front() : 32'hx);
        check("buffer running", 1'b0, ibuf_exec);
        @(posedge clk_in);
        #1 exec_done = 1'b1;
        @(posedge clk_in);
        #1 exec_done = 1'b0;
        $display("t_exec done");
    endtask

    task automatic t_baud;
        send_str("FFFFF903011");
        host.rx_clks = 48;
        send("2", "2");
        host.tx_clks = 48;
        chk_wr(`SBRL_BAUD_REG_LO, 8'h12);
        check("new divider", 1, div >= 16'h2e && div <= 16'h32);
        send(",", ",");
        $display("t_baud done");
    endtask

    initial begin
        t_modes();
        t_vectors();
        t_link();
        t_write();
        t_ibuf();
        t_comment();
        t_exec();
        t_baud();
        test_done();
    end
endmodule // tb_top
